// File: acl_pkg.sv
// Notes on behaviour
// - word load: low half set, upper zeroed
// - double load fills all 32 bits
// - pointer outside memory sets range flag
// - negative flag follows sign of loaded value
// - zero flag set on zero load
// - consecutive loads push previous accumulator
// - bit-field load gathers 1 to 32 bits
// - uncovered bit-field positions written zero
// - octal operand converted, loaded as 16 bits
// - indexed address is base plus stack level
// - stack offset taken as plain binary
// - indexed load fills low half, upper zeroed
// - accumulator cleared at every scan end
// - eight-level stack, deepest entry lost on push
//
// Purpose: constants and helpers of the accumulator load unit
// Assumes: one clock, sequencer and memories on the same clock
// Notes: op codes and states are binary enums
package acl_pkg;
    localparam int ACC_W = 32;
    localparam int WORD_W = 16;
    localparam int STACK_DEPTH_DEF = 8;
    localparam int WMEM_DEPTH_DEF = 8192;
    localparam logic [31:0] ACC_RESET = 32'h0000_0000;
    localparam logic [15:0] HALF_ZERO = 16'h0000;
    localparam logic [5:0] BITS_MIN = 6'h01;
    localparam logic [5:0] BITS_MAX = 6'h20;

    typedef enum logic [2:0] {
        word_load_op = 3'b000,
        double_word_load_op = 3'b001,
        bit_field_load_op = 3'b010,
        octal_address_load_op = 3'b011,
        indexed_word_load_op = 3'b100
    } acl_op_type;

    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_ptr = 3'b001,
        st_wlo = 3'b010,
        st_whi = 3'b011,
        st_bit = 3'b100
    } acl_state_type;

    // six octal digits, one per nibble, to binary
    function automatic logic [15:0] acl_oct_to_bin(input logic [23:0] d);
        logic [17:0] b;
        b = {d[22:20], d[18:16], d[14:12], d[10:8], d[6:4], d[2:0]};
        return b[15:0];
    endfunction : acl_oct_to_bin

    // low n bits set, n in 1..32
    function automatic logic [31:0] acl_field_mask(input logic [5:0] n);
        logic [63:0] m;
        m = (64'h0000_0000_0000_0001 << n) - 64'h0000_0000_0000_0001;
        return m[31:0];
    endfunction : acl_field_mask

    // clamp a requested bit count into 1..32
    function automatic logic [5:0] acl_clamp_bits(input logic [5:0] n);
        logic [5:0] c;
        c = n;
        if (n < BITS_MIN) begin
            c = BITS_MIN;
        end else if (n > BITS_MAX) begin
            c = BITS_MAX;
        end
        return c;
    endfunction : acl_clamp_bits
endpackage : acl_pkg

// File: acl_load_unit.sv
// Purpose: accumulator load unit, five load operations
// Assumes: sequencer and memories on clk, answers with valid while req high
// Notes: all state except the checking helpers in one packed struct, outputs taken from it
`timescale 1ns/10ps
`default_nettype none
module acl_load_unit
    import acl_pkg::*;
#(
    parameter int STACK_DEPTH = STACK_DEPTH_DEF,
    parameter int WMEM_DEPTH = WMEM_DEPTH_DEF
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic op_valid,
    input wire logic [2:0] op_code,
    input wire logic op_is_const,
    input wire logic op_ptr,
    input wire logic [15:0] op_addr,
    input wire logic [31:0] op_const,
    input wire logic [5:0] op_bit_count,
    input wire logic store_seen,
    input wire logic scan_end,
    input wire logic [15:0] mem_rd_data,
    input wire logic mem_rd_valid,
    input wire logic bit_rd_data,
    input wire logic bit_rd_valid,
    output logic op_busy,
    output logic op_done,
    output logic [31:0] acc,
    output logic [31:0] acc_stack_top,
    output logic pointer_range_flag,
    output logic negative_flag,
    output logic zero_flag,
    output logic mem_rd_req,
    output logic [15:0] mem_rd_addr,
    output logic bit_rd_req,
    output logic [15:0] bit_rd_addr
);
    typedef struct packed {
        acl_state_type state;
        acl_op_type op;
        logic [15:0] addr;
        logic [5:0] cnt;
        logic [5:0] idx;
        logic [31:0] gat;
        logic [15:0] lo;
        logic [31:0] acc;
        logic [STACK_DEPTH-1:0][31:0] stk;
        logic consec;
        logic neg;
        logic zero;
        logic prng;
        logic done;
        logic busy;
        logic mreq;
        logic breq;
    } acl_reg_type;

    acl_reg_type r_r;
    acl_reg_type r_nxt;
    logic fin;
    logic [31:0] val;
    logic [15:0] offset;
    logic go;
    logic [16:0] ptr_last;

    assign go = ce && op_valid && (r_r.state == st_idle);

    always_comb begin
        r_nxt = r_r;
        fin = 1'b0;
        val = ACC_RESET;
        ptr_last = 17'h0_0000;
        r_nxt.done = 1'b0;
        offset = (r_r.consec && !store_seen) ? r_r.acc[15:0] : r_r.stk[0][15:0];
        if (store_seen || scan_end) begin
            r_nxt.consec = 1'b0;
        end
        if (scan_end) begin
            r_nxt.prng = 1'b0;
        end
        case (r_r.state)
            st_idle: begin
                if (op_valid) begin
                    if (r_r.consec && !store_seen) begin
                        r_nxt.stk = {r_r.stk[STACK_DEPTH-2:0], r_r.acc};
                    end
                    r_nxt.op = acl_op_type'(op_code);
                    r_nxt.idx = 6'h00;
                    r_nxt.gat = ACC_RESET;
                    r_nxt.cnt = acl_clamp_bits(op_bit_count);
                    r_nxt.addr = op_addr;
                    case (acl_op_type'(op_code))
                        word_load_op, double_word_load_op: begin
                            if (op_is_const) begin
                                fin = 1'b1;
                                val = (op_code == word_load_op) ? {HALF_ZERO, op_const[15:0]} : op_const;
                            end else begin
                                r_nxt.mreq = 1'b1;
                                r_nxt.busy = 1'b1;
                                r_nxt.state = op_ptr ? st_ptr : st_wlo;
                            end
                        end
                        octal_address_load_op: begin
                            fin = 1'b1;
                            val = {HALF_ZERO, acl_oct_to_bin(op_const[23:0])};
                        end
                        indexed_word_load_op: begin
                            r_nxt.addr = op_addr + offset;
                            r_nxt.mreq = 1'b1;
                            r_nxt.busy = 1'b1;
                            r_nxt.state = st_wlo;
                        end
                        bit_field_load_op: begin
                            r_nxt.breq = 1'b1;
                            r_nxt.busy = 1'b1;
                            r_nxt.state = st_bit;
                        end
                        default: begin
                            // unknown code: no push, no side effect
                            r_nxt.stk = r_r.stk;
                            r_nxt.op = r_r.op;
                            r_nxt.idx = r_r.idx;
                            r_nxt.gat = r_r.gat;
                            r_nxt.cnt = r_r.cnt;
                            r_nxt.addr = r_r.addr;
                        end
                    endcase
                end
            end
            st_ptr: begin
                if (mem_rd_valid) begin
                    ptr_last = {1'b0, mem_rd_data};
                    if (r_r.op == double_word_load_op) begin
                        ptr_last = ptr_last + 17'h0_0001;
                    end
                    if (ptr_last >= 17'(WMEM_DEPTH)) begin
                        r_nxt.prng = 1'b1;
                        r_nxt.done = 1'b1;
                        r_nxt.busy = 1'b0;
                        r_nxt.mreq = 1'b0;
                        r_nxt.state = st_idle;
                    end else begin
                        r_nxt.addr = mem_rd_data;
                        r_nxt.state = st_wlo;
                    end
                end
            end
            st_wlo: begin
                if (mem_rd_valid) begin
                    if (r_r.op == double_word_load_op) begin
                        r_nxt.lo = mem_rd_data;
                        r_nxt.addr = r_r.addr + 16'h0001;
                        r_nxt.state = st_whi;
                    end else begin
                        fin = 1'b1;
                        val = {HALF_ZERO, mem_rd_data};
                    end
                end
            end
            st_whi: begin
                if (mem_rd_valid) begin
                    fin = 1'b1;
                    val = {mem_rd_data, r_r.lo};
                end
            end
            st_bit: begin
                if (bit_rd_valid) begin
                    r_nxt.gat[r_r.idx[4:0]] = bit_rd_data;
                    if (r_r.idx == r_r.cnt - 6'h01) begin
                        fin = 1'b1;
                        val = r_nxt.gat & acl_field_mask(r_r.cnt);
                    end else begin
                        r_nxt.idx = r_r.idx + 6'h01;
                        r_nxt.addr = r_r.addr + 16'h0001;
                    end
                end
            end
            default: begin
                r_nxt.state = st_idle;
                r_nxt.busy = 1'b0;
                r_nxt.mreq = 1'b0;
                r_nxt.breq = 1'b0;
            end
        endcase
        if (fin) begin
            r_nxt.acc = val;
            r_nxt.neg = val[31];
            r_nxt.zero = (val == ACC_RESET);
            r_nxt.done = 1'b1;
            r_nxt.busy = 1'b0;
            r_nxt.mreq = 1'b0;
            r_nxt.breq = 1'b0;
            r_nxt.consec = 1'b1;
            r_nxt.state = st_idle;
        end
        if (scan_end) begin
            r_nxt.acc = ACC_RESET;
            r_nxt.consec = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            r_r <= '0;
        end else if (ce) begin
            r_r <= r_nxt;
        end
    end

    assign op_busy = r_r.busy;
    assign op_done = r_r.done;
    assign acc = r_r.acc;
    assign acc_stack_top = r_r.stk[0];
    assign pointer_range_flag = r_r.prng;
    assign negative_flag = r_r.neg;
    assign zero_flag = r_r.zero;
    assign mem_rd_req = r_r.mreq;
    assign mem_rd_addr = r_r.addr;
    assign bit_rd_req = r_r.breq;
    assign bit_rd_addr = r_r.addr;

    // checking helpers
    logic [15:0] chk_lo_r;
    logic [31:0] chk_prev_r;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            chk_lo_r <= 16'h0000;
        end else if (ce && mem_rd_valid && r_r.state == st_wlo) begin
            chk_lo_r <= mem_rd_data;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            chk_prev_r <= 32'h0000_0000;
        end else if (ce) begin
            chk_prev_r <= r_r.stk[STACK_DEPTH-2];
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_push_go;
        go && r_r.consec && !store_seen && !scan_end && op_code <= 3'b100;
    endsequence
    sequence s_ptr_bad;
        ce && r_r.state == st_ptr && mem_rd_valid && r_r.op == word_load_op
            && {1'b0, mem_rd_data} >= 17'(WMEM_DEPTH);
    endsequence
    sequence s_const_word;
        go && op_code == word_load_op && op_is_const && !scan_end;
    endsequence
    sequence s_const_dword;
        go && op_code == double_word_load_op && op_is_const && !scan_end;
    endsequence

    a_word_upper_zero: assert property (op_done && r_r.op == word_load_op && !r_r.prng
        |-> acc[31:16] == HALF_ZERO) else $error("word load left upper half set");
    a_const_word_val: assert property (s_const_word |=> op_done
        && acc == {HALF_ZERO, $past(op_const[15:0])}) else $error("constant word not loaded");
    a_dword_const_val: assert property (s_const_dword |=> op_done
        && acc == $past(op_const)) else $error("constant double word not loaded");
    a_ptr_range_set: assert property (s_ptr_bad |=> pointer_range_flag && op_done
        && !op_busy) else $error("pointer range flag not set");
    a_neg_flag_sign: assert property (op_done && !$past(scan_end)
        |-> negative_flag == acc[31]) else $error("negative flag wrong");
    a_zero_flag_val: assert property (op_done && !$past(scan_end) && $changed(acc)
        |-> zero_flag == (acc == ACC_RESET)) else $error("zero flag wrong");
    a_push_prev_acc: assert property (s_push_go |=> acc_stack_top == $past(acc)
        && r_r.stk[STACK_DEPTH-1] == chk_prev_r) else $error("push lost");
    a_field_zero_fill: assert property (op_done && r_r.op == bit_field_load_op && !$past(scan_end)
        |-> (acc & ~acl_field_mask(r_r.cnt)) == ACC_RESET) else $error("field bits not zero");
    a_octal_upper_zero: assert property (go && op_code == octal_address_load_op && !scan_end
        |=> op_done && acc[31:16] == HALF_ZERO) else $error("octal load left upper half set");
    a_idx_upper_zero: assert property (op_done && r_r.op == indexed_word_load_op && !$past(scan_end)
        |-> acc[31:16] == HALF_ZERO) else $error("indexed load left upper half set");
    a_dword_low_half: assert property (op_done && r_r.op == double_word_load_op
        && $past(r_r.state) == st_whi && !$past(scan_end)
        |-> acc[15:0] == chk_lo_r) else $error("double word order wrong");
    a_scan_clear_acc: assert property (ce && scan_end |=> acc == ACC_RESET)
        else $error("accumulator not cleared at scan end");
    a_idx_addr_form: assert property (go && op_code == indexed_word_load_op
        |=> mem_rd_req && mem_rd_addr == $past(op_addr + offset)) else $error("indexed address wrong");
endmodule : acl_load_unit
`default_nettype wire

// File: acl_mem_model.sv
// Purpose: word and bit memory answering the load unit
// Assumes: answer while request high, four wait states when slow, three if the address was already held
// Notes: idle data lines invert every cycle, starting from the inverse of the last answer
`timescale 1ns/10ps
`default_nettype none
module acl_mem_model (
    input wire logic clk,
    input wire logic slow,
    input wire logic mem_rd_req,
    input wire logic [15:0] mem_rd_addr,
    output logic [15:0] mem_rd_data,
    output logic mem_rd_valid,
    input wire logic bit_rd_req,
    input wire logic [15:0] bit_rd_addr,
    output logic bit_rd_data,
    output logic bit_rd_valid
);
    logic [15:0] wmem [0:1023];
    logic bmem [0:1023];
    logic [15:0] w_last_a = 16'h0000;
    logic [15:0] b_last_a = 16'h0000;
    logic [15:0] w_last_d = 16'h0000;
    logic b_last_d = 1'h0;
    logic [1:0] w_cnt = 2'h0;
    logic [1:0] b_cnt = 2'h0;
    // slow answers need the same address held for four cycles
    always_comb begin
        mem_rd_valid = mem_rd_req && (!slow || (mem_rd_addr == w_last_a && w_cnt == 2'h3));
        bit_rd_valid = bit_rd_req && (!slow || (bit_rd_addr == b_last_a && b_cnt == 2'h3));
        mem_rd_data = mem_rd_valid ? wmem[mem_rd_addr[9:0]] : ~w_last_d;
        bit_rd_data = bit_rd_valid ? bmem[bit_rd_addr[9:0]] : ~b_last_d;
    end
    always_ff @(posedge clk) begin
        w_last_a <= mem_rd_addr;
        b_last_a <= bit_rd_addr;
        w_last_d <= mem_rd_data;
        b_last_d <= bit_rd_data;
        w_cnt <= (!mem_rd_req || mem_rd_addr != w_last_a || mem_rd_valid) ? 2'h0 : w_cnt + 2'h1;
        b_cnt <= (!bit_rd_req || bit_rd_addr != b_last_a || bit_rd_valid) ? 2'h0 : b_cnt + 2'h1;
    end
endmodule : acl_mem_model
`default_nettype wire

// File: acl_load_unit_bench.sv
// Purpose: self-checking bench of the accumulator load unit
// Assumes: memory model answers promptly or slowly
// Notes: table of plain loads first, then hand-written cases
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; \
    $display("wrong value at %0t: got %h want %h", $time, got, exp); end end
module acl_load_unit_bench
    import acl_pkg::*;
;
    typedef struct {
        logic [2:0] code;
        logic cst;
        logic ptr;
        logic [15:0] addr;
        logic [31:0] k;
        logic [5:0] n;
        logic [31:0] exp;
    } acl_row_type;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic ce = 1'h1;
    logic op_valid = 1'h0;
    logic [2:0] op_code = 3'h0;
    logic op_is_const = 1'h0;
    logic op_ptr = 1'h0;
    logic [15:0] op_addr = 16'h0000;
    logic [31:0] op_const = 32'h0000_0000;
    logic [5:0] op_bit_count = 6'h00;
    logic store_seen = 1'h0;
    logic scan_end = 1'h0;
    logic slow = 1'h0;
    logic [15:0] mem_rd_data, mem_rd_addr, bit_rd_addr;
    logic mem_rd_valid, bit_rd_data, bit_rd_valid, op_busy, op_done;
    logic [31:0] acc, acc_stack_top;
    logic pointer_range_flag, negative_flag, zero_flag, mem_rd_req, bit_rd_req;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    localparam logic [31:0] BITPAT = 32'hC35A_96E1;
    acl_row_type rows [12] = '{
        '{word_load_op, 1'h1, 1'h0, 16'h0000, 32'h1234_ABCD, 6'h00, 32'h0000_ABCD},
        '{word_load_op, 1'h0, 1'h0, 16'h0010, 32'h0000_0000, 6'h00, 32'h0000_1234},
        '{double_word_load_op, 1'h0, 1'h0, 16'h0010, 32'h0000_0000, 6'h00, 32'h8765_1234},
        '{double_word_load_op, 1'h1, 1'h0, 16'h0000, 32'h8000_0000, 6'h00, 32'h8000_0000},
        '{word_load_op, 1'h0, 1'h0, 16'h0012, 32'h0000_0000, 6'h00, 32'h0000_0000},
        '{double_word_load_op, 1'h0, 1'h0, 16'h0012, 32'h0000_0000, 6'h00, 32'h0000_0000},
        '{word_load_op, 1'h0, 1'h1, 16'h0014, 32'h0000_0000, 6'h00, 32'h0000_BEEF},
        '{bit_field_load_op, 1'h0, 1'h0, 16'h0050, 32'h0000_0000, 6'h07, 32'h0000_0061},
        '{bit_field_load_op, 1'h0, 1'h0, 16'h0050, 32'h0000_0000, 6'h20, BITPAT},
        '{bit_field_load_op, 1'h0, 1'h0, 16'h0051, 32'h0000_0000, 6'h01, 32'h0000_0000},
        '{octal_address_load_op, 1'h1, 1'h0, 16'h0000, 32'h0004_0400, 6'h00, 32'h0000_4100},
        '{octal_address_load_op, 1'h1, 1'h0, 16'h0000, 32'h0017_7777, 6'h00, 32'h0000_FFFF}
    };
    acl_load_unit #(.STACK_DEPTH(8), .WMEM_DEPTH(1024)) acl_load_unit_i (.clk(clk), .rst_b(rst_b), .ce(ce),
        .op_valid(op_valid), .op_code(op_code), .op_is_const(op_is_const), .op_ptr(op_ptr), .op_addr(op_addr),
        .op_const(op_const), .op_bit_count(op_bit_count), .store_seen(store_seen), .scan_end(scan_end),
        .mem_rd_data(mem_rd_data), .mem_rd_valid(mem_rd_valid), .bit_rd_data(bit_rd_data),
        .bit_rd_valid(bit_rd_valid), .op_busy(op_busy), .op_done(op_done), .acc(acc),
        .acc_stack_top(acc_stack_top), .pointer_range_flag(pointer_range_flag), .negative_flag(negative_flag),
        .zero_flag(zero_flag), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .bit_rd_req(bit_rd_req),
        .bit_rd_addr(bit_rd_addr));
    acl_mem_model acl_mem_model_i (.clk(clk), .slow(slow), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
        .mem_rd_data(mem_rd_data), .mem_rd_valid(mem_rd_valid), .bit_rd_req(bit_rd_req),
        .bit_rd_addr(bit_rd_addr), .bit_rd_data(bit_rd_data), .bit_rd_valid(bit_rd_valid));
    always #25 clk = ~clk;
    task automatic tally_and_finish();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            tally_and_finish();
        end
    end
    // offer one load and wait for its completion pulse
    task automatic run_op(input acl_row_type r);
        int n;
        n = 0;
        @(posedge clk);
        op_code <= r.code;
        op_is_const <= r.cst;
        op_ptr <= r.ptr;
        op_addr <= r.addr;
        op_const <= r.k;
        op_bit_count <= r.n;
        op_valid <= 1'h1;
        @(posedge clk);
        op_valid <= 1'h0;
        #1;
        // memory-using loads are busy right after the take
        `CHK(op_busy, !((r.code <= double_word_load_op && r.cst) || r.code == octal_address_load_op))
        while (op_done !== 1'h1 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 300) begin
            errors++;
            $display("wrong value at %0t: no completion", $time);
        end
    endtask : run_op
    task automatic pulse(input bit which);
        @(posedge clk);
        if (which) scan_end <= 1'h1;
        else store_seen <= 1'h1;
        @(posedge clk);
        scan_end <= 1'h0;
        store_seen <= 1'h0;
        #1;
    endtask : pulse
    // negative and zero flags move only on completed loads and reset; range flag sets on abort, clears at scan end and reset
    task automatic check_acc(input logic [31:0] exp, input logic rng, input logic z);
        `CHK(acc, exp)
        `CHK(negative_flag, exp[31])
        `CHK(zero_flag, z)
        `CHK(pointer_range_flag, rng)
    endtask : check_acc
    initial begin
        for (int i = 0; i < 1024; i++) begin
            acl_mem_model_i.wmem[i] = 16'(i) ^ 16'hA5A5;
            acl_mem_model_i.bmem[i] = 1'(i);
        end
        for (int i = 0; i < 32; i++) acl_mem_model_i.bmem[16'h0050 + i] = BITPAT[i];
        acl_mem_model_i.wmem[16'h0010] = 16'h1234;
        acl_mem_model_i.wmem[16'h0011] = 16'h8765;
        acl_mem_model_i.wmem[16'h0012] = 16'h0000;
        acl_mem_model_i.wmem[16'h0013] = 16'h0000;
        acl_mem_model_i.wmem[16'h0014] = 16'h0300;
        acl_mem_model_i.wmem[16'h0015] = 16'h0400;
        acl_mem_model_i.wmem[16'h0016] = 16'h03FF;
        acl_mem_model_i.wmem[16'h0300] = 16'hBEEF;
        acl_mem_model_i.wmem[16'h0115] = 16'h2345;
        acl_mem_model_i.wmem[16'h0116] = 16'hF00D;
        repeat (2) @(posedge clk);
        rst_b <= 1'h1;
        #1;
        check_acc(32'h0000_0000, 1'h0, 1'h0);
        `CHK(op_done, 1'h0)
        $display("test reset done");
        for (int s = 0; s < 2; s++) begin
            slow = 1'(s);
            foreach (rows[i]) begin
                pulse(1'h1);
                run_op(rows[i]);
                check_acc(rows[i].exp, 1'h0, rows[i].exp == 32'h0000_0000);
            end
        end
        $display("test table done");
        pulse(1'h1);
        for (int i = 1; i <= 9; i++) begin
            run_op('{word_load_op, 1'h1, 1'h0, 16'h0000, 32'(i), 6'h00, 32'h0000_0000});
            if (i > 1) `CHK(acc_stack_top, 32'(i - 1))
        end
        pulse(1'h0);
        run_op('{word_load_op, 1'h1, 1'h0, 16'h0000, 32'h0000_0077, 6'h00, 32'h0000_0000});
        `CHK(acc_stack_top, 32'h0000_0008)
        $display("test push done");
        pulse(1'h1);
        run_op('{octal_address_load_op, 1'h1, 1'h0, 16'h0000, 32'h0000_0025, 6'h00, 32'h0000_0000});
        run_op('{indexed_word_load_op, 1'h0, 1'h0, 16'h0100, 32'h0000_0000, 6'h00, 32'h0000_0000});
        check_acc(32'h0000_2345, 1'h0, 1'h0);
        `CHK(acc_stack_top, 32'h0000_0015)
        run_op('{octal_address_load_op, 1'h1, 1'h0, 16'h0000, 32'h0000_0026, 6'h00, 32'h0000_0000});
        run_op('{indexed_word_load_op, 1'h0, 1'h0, 16'h0100, 32'h0000_0000, 6'h00, 32'h0000_0000});
        check_acc(32'h0000_F00D, 1'h0, 1'h0);
        $display("test indexed done");
        pulse(1'h1);
        run_op('{double_word_load_op, 1'h0, 1'h1, 16'h0016, 32'h0000_0000, 6'h00, 32'h0000_0000});
        check_acc(32'h0000_0000, 1'h1, 1'h0);
        pulse(1'h1);
        `CHK(pointer_range_flag, 1'h0)
        run_op('{word_load_op, 1'h0, 1'h1, 16'h0015, 32'h0000_0000, 6'h00, 32'h0000_0000});
        `CHK(pointer_range_flag, 1'h1)
        run_op('{word_load_op, 1'h1, 1'h0, 16'h0000, 32'h0000_1234, 6'h00, 32'h0000_0000});
        `CHK(pointer_range_flag, 1'h1)
        pulse(1'h1);
        check_acc(32'h0000_0000, 1'h0, 1'h0);
        $display("test range and scan done");
        // offer a load while the enable is low: nothing may move
        @(posedge clk);
        ce <= 1'h0;
        op_code <= word_load_op;
        op_is_const <= 1'h1;
        op_const <= 32'h0000_5555;
        op_valid <= 1'h1;
        repeat (3) @(posedge clk);
        #1;
        `CHK(op_done, 1'h0)
        `CHK(acc, 32'h0000_0000)
        @(posedge clk);
        ce <= 1'h1;
        @(posedge clk);
        op_valid <= 1'h0;
        ce <= 1'h0;
        @(posedge clk);
        #1;
        `CHK(op_done, 1'h1)
        `CHK(acc, 32'h0000_5555)
        @(posedge clk);
        ce <= 1'h1;
        $display("test enable done");
        @(posedge clk);
        rst_b <= 1'h0;
        @(posedge clk);
        rst_b <= 1'h1;
        #1;
        check_acc(32'h0000_0000, 1'h0, 1'h0);
        `CHK(acc_stack_top, 32'h0000_0000)
        `CHK(op_done, 1'h0)
        $display("test reset again done");
        tally_and_finish();
    end
endmodule : acl_load_unit_bench
`undef CHK
`default_nettype wire
